// ---- hdl/bbx_pkg.sv ----
// Constants, encodings and types of the bit, block and port execution unit
// How it works
// - Register bit set forces the bit to one, keeps flags, 8 T states.
// - Register bit clear forces the bit to zero, keeps flags, 8 T states.
// - Bit test loads Z with inverted bit, sets H, clears N, keeps C.
// - Memory bit set or clear touches one bit; 15 or 23 T states.
// - Memory bit test flags behave exactly like the register form.
// - Memory shifts take carry from the shifted-out bit; S, Z, P from result.
// - Bank swap exchanges three pairs with alternates at once in 4 T states.
// - Stack-top exchange swaps HL, IX or IY with the word at SP, low byte at SP; 19 or 23 T states.
// - Incrementing copy moves a byte, steps pointers up, PV shows count nonzero.
// - Decrementing copy is the same but steps both pointers down.
// - Incrementing compare subtracts memory from A, sets flags, steps pointer up.
// - Decrementing compare uses the same flags but steps the pointer down.
// - Repeats rewind the program counter; 21 T states each, last one 16.
// - Repeating incrementing copy runs until count zero, leaving PV, H, N clear.
// - Repeating decrementing copy steps pointers down with the same flag results.
// - Repeating incrementing compare stops on count zero or on a match.
// - Repeating decrementing compare steps down and stops on zero or match.
// - Direct port input loads A from the immediate port, no flags, 11 T.
// - Port input via C loads a register, sets S Z P, clears H N, 12 T.
// - Incrementing block input stores port byte at pointer, steps, Z on zero.
package bbx_pkg;
	localparam logic [7:0] PFX_BIT = 8'hCB;
	localparam logic [7:0] PFX_EXT = 8'hED;
	localparam logic [7:0] PFX_IX = 8'hDD;
	localparam logic [7:0] PFX_IY = 8'hFD;
	localparam logic [7:0] OP_SWAP = 8'hD9;
	localparam logic [7:0] OP_EXSP = 8'hE3;
	localparam logic [7:0] OP_IN_N = 8'hDB;
	localparam logic [7:0] OP_INI = 8'hA2;
	localparam logic [7:0] BLK_MASK = 8'hE6;
	localparam logic [7:0] BLK_MATCH = 8'hA0;
	localparam logic [4:0] T_BIT_R = 5'h08;
	localparam logic [4:0] T_BIT_P = 5'h0F;
	localparam logic [4:0] T_BIT_X = 5'h17;
	localparam logic [4:0] T_EXSP_P = 5'h13;
	localparam logic [4:0] T_EXSP_X = 5'h17;
	localparam logic [4:0] T_SWAP = 5'h04;
	localparam logic [4:0] T_BLK = 5'h10;
	localparam logic [4:0] T_REP = 5'h15;
	localparam logic [4:0] T_EXTRA = T_REP - T_BLK;
	localparam logic [4:0] T_IN_N = 5'h0B;
	localparam logic [4:0] T_IO_C = 5'h0C;
	localparam logic [4:0] T_NONE = 5'h04;
	localparam logic [7:0] FM_S = 8'h80;
	localparam logic [7:0] FM_Z = 8'h40;
	localparam logic [7:0] FM_H = 8'h10;
	localparam logic [7:0] FM_PV = 8'h04;
	localparam logic [7:0] FM_N = 8'h02;
	localparam logic [7:0] FM_C = 8'h01;
	localparam logic [2:0] RI_B = 3'h0;
	localparam logic [2:0] RI_C = 3'h1;
	localparam logic [2:0] RI_H = 3'h4;
	localparam logic [2:0] RI_L = 3'h5;
	localparam logic [2:0] RI_F = 3'h6;
	localparam logic [2:0] RI_A = 3'h7;
	localparam logic [2:0] LS_AF = 3'h0;
	localparam logic [2:0] LS_BC = 3'h1;
	localparam logic [2:0] LS_DE = 3'h2;
	localparam logic [2:0] LS_HL = 3'h3;
	localparam logic [2:0] LS_IX = 3'h4;
	localparam logic [2:0] LS_IY = 3'h5;
	localparam logic [2:0] LS_SP = 3'h6;
	localparam logic [2:0] LS_PC = 3'h7;
	localparam logic [15:0] RST_WORD = 16'h0000;
	typedef enum {ST_IDLE, ST_RUN} bbx_state_t;
	typedef enum {CL_NONE, CL_BITR, CL_BITM, CL_SWAP, CL_EXSP, CL_COPY, CL_CMP,
		CL_INN, CL_INC, CL_OUTC, CL_INI} bbx_cls_t;
endpackage

// ---- hdl/bbx_exec.sv ----
// Execution unit for bit, shift, exchange, block and port instructions
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module bbx_exec (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        instr_valid,
	input  wire logic [7:0]  instr_b0,
	input  wire logic [7:0]  instr_b1,
	input  wire logic [7:0]  instr_b2,
	input  wire logic [7:0]  instr_b3,
	input  wire logic        ld_valid,
	input  wire logic [2:0]  ld_sel,
	input  wire logic [15:0] ld_data,
	input  wire logic [7:0]  bus_rdata,
	output logic             busy,
	output logic             done,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic             io_rd,
	output logic             io_wr,
	output logic [15:0]      bus_addr,
	output logic [7:0]       bus_wdata,
	output logic [15:0]      reg_af,
	output logic [15:0]      reg_bc,
	output logic [15:0]      reg_de,
	output logic [15:0]      reg_hl,
	output logic [15:0]      reg_ix,
	output logic [15:0]      reg_iy,
	output logic [15:0]      reg_sp,
	output logic [15:0]      reg_pc
);
	logic [7:0]           r8 [0:7];
	logic [7:0]           alt [0:5];
	logic [15:0]          ix;
	logic [15:0]          iy;
	logic [15:0]          sp;
	logic [15:0]          pc;
	bbx_pkg::bbx_state_t  state;
	bbx_pkg::bbx_cls_t    cls;
	logic [7:0]           op;
	logic [7:0]           disp;
	logic [7:0]           imm;
	logic [7:0]           tmp;
	logic                 pidx;
	logic                 use_iy;
	logic [4:0]           cnt;
	logic [2:0]           st;

	function automatic logic [7:0] szp(input logic [7:0] v);
		szp = {v[7], ~|v, 3'h0, ~^v, 2'h0};
	endfunction

	// Carry out in bit 8, result below
	function automatic logic [8:0] shf(input logic [2:0] k, input logic [7:0] v, input logic ci);
		unique case (k)
			3'h0: shf = {v[7], v[6:0], v[7]};
			3'h1: shf = {v[0], v[0], v[7:1]};
			3'h2: shf = {v[7], v[6:0], ci};
			3'h3: shf = {v[0], ci, v[7:1]};
			3'h4: shf = {v[7], v[6:0], 1'h0};
			3'h5: shf = {v[0], v[7], v[7:1]};
			3'h6: shf = {v[7], v[6:0], 1'h1};
			3'h7: shf = {v[0], 1'h0, v[7:1]};
		endcase
	endfunction

	function automatic bbx_pkg::bbx_cls_t dec_cls(input logic [7:0] b0, input logic [7:0] b1,
			input logic [7:0] b3);
		dec_cls = bbx_pkg::CL_NONE;
		if (b0 == bbx_pkg::PFX_BIT) begin
			dec_cls = (b1[2:0] == bbx_pkg::RI_F) ? bbx_pkg::CL_BITM : bbx_pkg::CL_BITR;
		end else if (b0 == bbx_pkg::PFX_IX || b0 == bbx_pkg::PFX_IY) begin
			if (b1 == bbx_pkg::PFX_BIT && b3[2:0] == bbx_pkg::RI_F)
				dec_cls = bbx_pkg::CL_BITM;
			else if (b1 == bbx_pkg::OP_EXSP)
				dec_cls = bbx_pkg::CL_EXSP;
		end else if (b0 == bbx_pkg::OP_SWAP) begin
			dec_cls = bbx_pkg::CL_SWAP;
		end else if (b0 == bbx_pkg::OP_EXSP) begin
			dec_cls = bbx_pkg::CL_EXSP;
		end else if (b0 == bbx_pkg::OP_IN_N) begin
			dec_cls = bbx_pkg::CL_INN;
		end else if (b0 == bbx_pkg::PFX_EXT) begin
			if ((b1 & bbx_pkg::BLK_MASK) == bbx_pkg::BLK_MATCH)
				dec_cls = b1[0] ? bbx_pkg::CL_CMP : bbx_pkg::CL_COPY;
			else if (b1 == bbx_pkg::OP_INI)
				dec_cls = bbx_pkg::CL_INI;
			else if (b1[7:6] == 2'h1 && b1[2:0] == 3'h0)
				dec_cls = bbx_pkg::CL_INC;
			else if (b1[7:6] == 2'h1 && b1[2:0] == 3'h1)
				dec_cls = bbx_pkg::CL_OUTC;
		end
	endfunction

	function automatic logic [4:0] t_of(input bbx_pkg::bbx_cls_t c, input logic x);
		unique case (c)
			bbx_pkg::CL_BITR: t_of = bbx_pkg::T_BIT_R;
			bbx_pkg::CL_BITM: t_of = x ? bbx_pkg::T_BIT_X : bbx_pkg::T_BIT_P;
			bbx_pkg::CL_EXSP: t_of = x ? bbx_pkg::T_EXSP_X : bbx_pkg::T_EXSP_P;
			bbx_pkg::CL_SWAP: t_of = bbx_pkg::T_SWAP;
			bbx_pkg::CL_COPY: t_of = bbx_pkg::T_BLK;
			bbx_pkg::CL_CMP: t_of = bbx_pkg::T_BLK;
			bbx_pkg::CL_INI: t_of = bbx_pkg::T_BLK;
			bbx_pkg::CL_INN: t_of = bbx_pkg::T_IN_N;
			bbx_pkg::CL_INC: t_of = bbx_pkg::T_IO_C;
			bbx_pkg::CL_OUTC: t_of = bbx_pkg::T_IO_C;
			bbx_pkg::CL_NONE: t_of = bbx_pkg::T_NONE;
		endcase
	endfunction

	// Instruction decode, only looked at in the accept cycle
	wire              is_idx_pfx = instr_b0 == bbx_pkg::PFX_IX || instr_b0 == bbx_pkg::PFX_IY;
	wire              is_two = instr_b0 == bbx_pkg::PFX_BIT || instr_b0 == bbx_pkg::PFX_EXT
		|| instr_b0 == bbx_pkg::OP_IN_N;
	wire              is_xbit = is_idx_pfx && instr_b1 == bbx_pkg::PFX_BIT;
	wire [7:0]        dec_op = is_xbit ? instr_b3 : (is_two ? instr_b1 : instr_b0);
	wire [15:0]       dec_len = is_xbit ? 16'h0004 : ((is_two || is_idx_pfx) ? 16'h0002 : 16'h0001);
	bbx_pkg::bbx_cls_t dec_c;
	assign dec_c = dec_cls(instr_b0, instr_b1, instr_b3);
	wire              accept = state == bbx_pkg::ST_IDLE && instr_valid;

	// Operand paths
	wire [7:0]  f = r8[bbx_pkg::RI_F];
	wire [7:0]  acc = r8[bbx_pkg::RI_A];
	wire [15:0] bc = {r8[0], r8[1]};
	wire [15:0] de = {r8[2], r8[3]};
	wire [15:0] hl = {r8[4], r8[5]};
	wire [15:0] idx = use_iy ? iy : ix;
	wire [15:0] ea = pidx ? idx + {{8{disp[7]}}, disp} : hl;
	wire [15:0] pair = pidx ? idx : hl;
	wire [2:0]  bsel = op[5:3];
	wire [2:0]  rsel = op[2:0];
	wire        is_bitr = cls == bbx_pkg::CL_BITR;
	wire        is_exsp = cls == bbx_pkg::CL_EXSP;
	wire        is_copy = cls == bbx_pkg::CL_COPY;
	wire        is_cmp = cls == bbx_pkg::CL_CMP;
	wire        is_port = cls == bbx_pkg::CL_INN || cls == bbx_pkg::CL_INC
		|| cls == bbx_pkg::CL_INI || cls == bbx_pkg::CL_OUTC;
	wire [7:0]  opnd = is_bitr ? r8[rsel] : bus_rdata;
	wire [8:0]  shr = shf(bsel, opnd, f[0]);
	wire [7:0]  bmask = 8'h01 << bsel;
	wire        is_test = op[7:6] == 2'h1;
	wire [7:0]  bit_res = (op[7:6] == 2'h0) ? shr[7:0] : (op[6] ? opnd | bmask : opnd & ~bmask);
	wire [7:0]  f_test = (f & ~(bbx_pkg::FM_Z | bbx_pkg::FM_H | bbx_pkg::FM_N)) | bbx_pkg::FM_H
		| (((opnd & bmask) == 8'h00) ? bbx_pkg::FM_Z : 8'h00);
	wire [7:0]  f_shift = szp(shr[7:0]) | {7'h00, shr[8]};
	wire [7:0]  diff = acc - bus_rdata;
	wire        hbor = acc[3:0] < bus_rdata[3:0];
	wire [15:0] bc_dec = bc - 16'h0001;
	wire        bc_nz = |bc_dec;
	wire [15:0] step = op[3] ? 16'hFFFF : 16'h0001;
	wire [7:0]  f_copy = (f & (bbx_pkg::FM_S | bbx_pkg::FM_Z | bbx_pkg::FM_C))
		| (bc_nz ? bbx_pkg::FM_PV : 8'h00);
	wire [7:0]  f_cmp = (f & bbx_pkg::FM_C) | {diff[7], ~|diff, 1'h0, hbor, 1'h0, bc_nz, 2'h2};
	wire [7:0]  b_dec = r8[bbx_pkg::RI_B] - 8'h01;
	wire [7:0]  f_ini = (f & ~bbx_pkg::FM_Z) | bbx_pkg::FM_N
		| ((b_dec == 8'h00) ? bbx_pkg::FM_Z : 8'h00);
	wire [7:0]  f_in = (f & bbx_pkg::FM_C) | szp(bus_rdata);
	wire [7:0]  out_r = (bsel == bbx_pkg::RI_F) ? 8'h00 : r8[bsel];
	// Repeat only while count remains and, for compares, no match yet
	wire        again = op[4] && bc_nz && (is_copy || (is_cmp && diff != 8'h00));
	wire        run = state == bbx_pkg::ST_RUN;
	wire        s0 = run && st == 3'h0;
	wire        s1 = run && st == 3'h1;
	wire        s2 = run && st == 3'h2;
	wire        s3 = run && st == 3'h3;

	// Bus strobes issued one cycle after the step that decides them
	wire        next_mem_rd = (s0 && (cls == bbx_pkg::CL_BITM || is_exsp || is_copy || is_cmp))
		|| (s1 && is_exsp);
	wire        next_io_rd = s0 && is_port && cls != bbx_pkg::CL_OUTC;
	wire        next_io_wr = s0 && cls == bbx_pkg::CL_OUTC;
	wire        next_mem_wr = (s2 && ((cls == bbx_pkg::CL_BITM && !is_test) || is_exsp || is_copy
		|| cls == bbx_pkg::CL_INI)) || (s3 && is_exsp);
	wire [15:0] addr_io = (cls == bbx_pkg::CL_INN) ? {acc, imm} : bc;
	wire [15:0] next_addr = is_exsp ? (st[0] ? sp + 16'h0001 : sp)
		: (cls == bbx_pkg::CL_BITM) ? ea
		: (is_copy && st == 3'h2) ? de
		: (is_port && st == 3'h0) ? addr_io : hl;
	wire [7:0]  next_wdata = is_exsp ? (st[0] ? pair[15:8] : pair[7:0])
		: (cls == bbx_pkg::CL_BITM) ? bit_res
		: (cls == bbx_pkg::CL_OUTC) ? out_r : bus_rdata;

	assign reg_af = {acc, f};
	assign reg_bc = bc;
	assign reg_de = de;
	assign reg_hl = hl;
	assign reg_ix = ix;
	assign reg_iy = iy;
	assign reg_sp = sp;
	assign reg_pc = pc;

	// Sequencer: run lasts exactly the T count, one cycle per T state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= bbx_pkg::ST_IDLE;
			busy <= 1'h0;
			done <= 1'h0;
			cnt <= 5'h00;
			st <= 3'h0;
		end else if (ce) begin
			done <= 1'h0;
			if (accept) begin
				state <= bbx_pkg::ST_RUN;
				busy <= 1'h1;
				cnt <= t_of(dec_c, is_idx_pfx) - 5'h01;
				st <= 3'h0;
			end else if (run) begin
				if (cnt == 5'h00) begin
					state <= bbx_pkg::ST_IDLE;
					busy <= 1'h0;
					done <= 1'h1;
				end else begin
					cnt <= (s2 && again) ? cnt + bbx_pkg::T_EXTRA - 5'h01 : cnt - 5'h01;
				end
				if (st != 3'h7)
					st <= st + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mem_rd <= 1'h0;
			mem_wr <= 1'h0;
			io_rd <= 1'h0;
			io_wr <= 1'h0;
			bus_addr <= bbx_pkg::RST_WORD;
			bus_wdata <= 8'h00;
		end else if (ce) begin
			mem_rd <= next_mem_rd;
			mem_wr <= next_mem_wr;
			io_rd <= next_io_rd;
			io_wr <= next_io_wr;
			bus_addr <= next_addr;
			bus_wdata <= next_wdata;
		end
	end

	// Register file; loads only while idle so they never race an instruction
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < 8; i++)
				r8[i] <= 8'h00;
			for (int i = 0; i < 6; i++)
				alt[i] <= 8'h00;
			ix <= bbx_pkg::RST_WORD;
			iy <= bbx_pkg::RST_WORD;
			sp <= bbx_pkg::RST_WORD;
			pc <= bbx_pkg::RST_WORD;
			cls <= bbx_pkg::CL_NONE;
			op <= 8'h00;
			disp <= 8'h00;
			imm <= 8'h00;
			tmp <= 8'h00;
			pidx <= 1'h0;
			use_iy <= 1'h0;
		end else if (ce) begin
			if (accept) begin
				cls <= dec_c;
				op <= dec_op;
				pidx <= is_idx_pfx;
				use_iy <= instr_b0 == bbx_pkg::PFX_IY;
				disp <= instr_b2;
				imm <= instr_b1;
				pc <= pc + dec_len;
			end else if (state == bbx_pkg::ST_IDLE && ld_valid) begin
				unique case (ld_sel)
					bbx_pkg::LS_AF: {r8[bbx_pkg::RI_A], r8[bbx_pkg::RI_F]} <= ld_data;
					bbx_pkg::LS_BC: {r8[0], r8[1]} <= ld_data;
					bbx_pkg::LS_DE: {r8[2], r8[3]} <= ld_data;
					bbx_pkg::LS_HL: {r8[4], r8[5]} <= ld_data;
					bbx_pkg::LS_IX: ix <= ld_data;
					bbx_pkg::LS_IY: iy <= ld_data;
					bbx_pkg::LS_SP: sp <= ld_data;
					bbx_pkg::LS_PC: pc <= ld_data;
				endcase
			end else if (run) begin
				unique case (cls)
					bbx_pkg::CL_BITR: begin
						if (s0 && is_test)
							r8[bbx_pkg::RI_F] <= f_test;
						else if (s0 && op[7:6] == 2'h0) begin
							r8[rsel] <= shr[7:0];
							r8[bbx_pkg::RI_F] <= f_shift;
						end else if (s0)
							r8[rsel] <= bit_res;
					end
					bbx_pkg::CL_BITM: begin
						if (s2 && is_test)
							r8[bbx_pkg::RI_F] <= f_test;
						else if (s2 && op[7:6] == 2'h0)
							r8[bbx_pkg::RI_F] <= f_shift;
					end
					bbx_pkg::CL_SWAP: begin
						if (s0) begin
							for (int i = 0; i < 6; i++) begin
								r8[i] <= alt[i];
								alt[i] <= r8[i];
							end
						end
					end
					bbx_pkg::CL_EXSP: begin
						if (s2)
							tmp <= bus_rdata;
						if (s3 && !pidx)
							{r8[bbx_pkg::RI_H], r8[bbx_pkg::RI_L]} <= {bus_rdata, tmp};
						else if (s3 && use_iy)
							iy <= {bus_rdata, tmp};
						else if (s3)
							ix <= {bus_rdata, tmp};
					end
					bbx_pkg::CL_COPY: begin
						if (s2) begin
							{r8[4], r8[5]} <= hl + step;
							{r8[2], r8[3]} <= de + step;
							{r8[0], r8[1]} <= bc_dec;
							r8[bbx_pkg::RI_F] <= f_copy;
						end
						if (s2 && again)
							pc <= pc - 16'h0002;
					end
					bbx_pkg::CL_CMP: begin
						if (s2) begin
							{r8[4], r8[5]} <= hl + step;
							{r8[0], r8[1]} <= bc_dec;
							r8[bbx_pkg::RI_F] <= f_cmp;
						end
						if (s2 && again)
							pc <= pc - 16'h0002;
					end
					bbx_pkg::CL_INN: begin
						if (s2)
							r8[bbx_pkg::RI_A] <= bus_rdata;
					end
					bbx_pkg::CL_INC: begin
						if (s2 && bsel != bbx_pkg::RI_F)
							r8[bsel] <= bus_rdata;
						if (s2)
							r8[bbx_pkg::RI_F] <= f_in;
					end
					bbx_pkg::CL_INI: begin
						if (s2) begin
							{r8[4], r8[5]} <= hl + 16'h0001;
							r8[bbx_pkg::RI_B] <= b_dec;
							r8[bbx_pkg::RI_F] <= f_ini;
						end
					end
					bbx_pkg::CL_OUTC: ;
					bbx_pkg::CL_NONE: ;
				endcase
			end
		end
	end

	// Checking aids: flags at accept, pc as advanced by the accept step, length of the run
	logic [7:0]  f_start;
	logic [15:0] pc_start;
	logic [4:0]  run_len;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			f_start <= 8'h00;
			pc_start <= bbx_pkg::RST_WORD;
			run_len <= 5'h00;
		end else if (ce && accept) begin
			f_start <= f;
			pc_start <= pc + dec_len;
			run_len <= 5'h00;
		end else if (ce && run) begin
			run_len <= run_len + 5'h01;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence copy_read_s;
		mem_rd && is_copy && ce ##1 ce;
	endsequence
	sequence copy_write_s;
		mem_wr && bus_addr == $past(de, 2) && bus_wdata == $past(bus_rdata);
	endsequence

	set_flags_a: assert property (done && is_bitr && op[7:6] == 2'h3 |-> f == f_start && run_len == 5'd8 && r8[rsel][bsel]) else $error("bit set changed flags or length");
	clr_reg_a: assert property (done && is_bitr && op[7:6] == 2'h2 |-> !r8[rsel][bsel] && f == f_start && run_len == 5'd8) else $error("bit clear wrong");
	bit_test_a: assert property (done && is_bitr && is_test |-> f[6] == !r8[rsel][bsel] && f[4] && !f[1] && f[0] == f_start[0]) else $error("bit test flags wrong");
	mem_bit_time_a: assert property (done && cls == bbx_pkg::CL_BITM && op[7] |-> run_len == (pidx ? 5'd23 : 5'd15) && f == f_start) else $error("memory bit op wrong");
	swap_time_a: assert property (done && cls == bbx_pkg::CL_SWAP |-> run_len == 5'd4 && f == f_start) else $error("bank swap wrong");
	exsp_time_a: assert property (done && is_exsp |-> run_len == (pidx ? 5'd23 : 5'd19) && f == f_start) else $error("stack exchange length wrong");
	copy_flags_a: assert property (done && is_copy |-> !f[4] && !f[1] && f[2] == (bc != 16'h0000)) else $error("copy flags wrong");
	copy_move_a: assert property (copy_read_s |=> copy_write_s) else $error("copy byte not moved");
	repeat_len_a: assert property (done && (is_copy || is_cmp) && op[4] |-> run_len == ((pc != pc_start) ? 5'd21 : 5'd16)) else $error("repeat length wrong");
	cmp_stop_a: assert property (done && is_cmp && op[4] && pc == pc_start |-> bc == 16'h0000 || f[6]) else $error("compare repeat stopped early");
	in_direct_a: assert property (done && cls == bbx_pkg::CL_INN |-> f == f_start && run_len == 5'd11) else $error("direct input wrong");
	port_addr_a: assert property (io_rd || io_wr |-> bus_addr[7:0] == ((cls == bbx_pkg::CL_INN) ? imm : r8[bbx_pkg::RI_C])) else $error("port address wrong");
endmodule // bbx_exec
`default_nettype wire

// ---- test/bbx_mem_model.sv ----
// Behavioural memory and port devices facing the execution unit
`timescale 1ns/10ps
`default_nettype none
module bbx_mem_model (
	input  wire logic        ref_clk,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic        io_rd,
	input  wire logic        io_wr,
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_wdata,
	output logic      [7:0]  bus_rdata
);
	// Only the low address byte decodes, so memory aliases every 256 bytes
	logic [7:0]  mem [0:255];
	logic [7:0]  io [0:255];
	logic [15:0] io_addr;
	initial bus_rdata = 8'hA5;
	initial io_addr = 16'h0000;
	// Known contents everywhere, so repeat copies past the seeded bytes move no unknowns
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i);
			io[i] = 8'(~i);
		end
	end
	always @(posedge ref_clk) begin
		// Idle data toggles so a stale byte is never mistaken for an answer
		if (mem_rd)
			bus_rdata <= mem[bus_addr[7:0]];
		else if (io_rd)
			bus_rdata <= io[bus_addr[7:0]];
		else
			bus_rdata <= ~bus_rdata;
		if (mem_wr)
			mem[bus_addr[7:0]] <= bus_wdata;
		if (io_wr)
			io[bus_addr[7:0]] <= bus_wdata;
		if (io_rd | io_wr)
			io_addr <= bus_addr;
	end
endmodule // bbx_mem_model
`default_nettype wire

// ---- test/tb_bit_block_io_instr_exec.sv ----
// Self-checking bench of the bit, block and port execution unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %0t: got %h want %h", $time, g, e); end end
module tb_bit_block_io_instr_exec;
	logic        ref_clk, rst, ce, instr_valid, ld_valid, last;
	logic        busy, done, mem_rd, mem_wr, io_rd, io_wr;
	logic [7:0]  b0, b1, b2, b3, bus_rdata, bus_wdata, a, m, v, f, d, ea, pv;
	logic [2:0]  ld_sel, r, b;
	logic [15:0] ld_data, bus_addr, dir, pc0, bc0, de0, hl0;
	logic [15:0] reg_af, reg_bc, reg_de, reg_hl, reg_ix, reg_iy, reg_sp, reg_pc;
	int          n_mismatch, n_tests, seed, n, j;
	bbx_exec u_dut (.ref_clk, .rst, .ce, .instr_valid, .instr_b0(b0), .instr_b1(b1),
		.instr_b2(b2), .instr_b3(b3), .ld_valid, .ld_sel, .ld_data, .bus_rdata, .busy,
		.done, .mem_rd, .mem_wr, .io_rd, .io_wr, .bus_addr, .bus_wdata, .reg_af, .reg_bc,
		.reg_de, .reg_hl, .reg_ix, .reg_iy, .reg_sp, .reg_pc);
	bbx_mem_model u_mem (.ref_clk, .mem_rd, .mem_wr, .io_rd, .io_wr, .bus_addr,
		.bus_wdata, .bus_rdata);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] get_r(input logic [2:0] s);
		case (s)
		3'h0: return reg_bc[15:8];
		3'h1: return reg_bc[7:0];
		3'h2: return reg_de[15:8];
		3'h3: return reg_de[7:0];
		3'h4: return reg_hl[15:8];
		3'h5: return reg_hl[7:0];
		default: return reg_af[15:8];
		endcase
	endfunction
	function automatic logic [7:0] szp(input logic [7:0] x);
		return {x[7], x == 8'h00, 3'h0, ~^x, 2'h0};
	endfunction
	function automatic logic [7:0] cmpf(input logic [7:0] x, input logic [7:0] y);
		logic [7:0] df;
		df = x - y;
		return {df[7], x == y, 1'b0, x[3:0] < y[3:0], 2'h0, 1'b1, 1'b0};
	endfunction
	task automatic ld(input logic [2:0] s, input logic [15:0] dv);
		@(posedge ref_clk);
		ld_valid <= 1'b1;
		ld_sel <= s;
		ld_data <= dv;
		@(posedge ref_clk);
		ld_valid <= 1'b0;
		#1;
	endtask
	task automatic run(input logic [31:0] w, input int t);
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		{b0, b1, b2, b3} <= w;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 60);
		`CHK(n, t)
		`CHK(busy, 1'b0)
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		summarize();
	end
	initial begin
		seed = 32'hc37e6384;
		{rst, ce, instr_valid, ld_valid, ld_sel, ld_data} = {2'b11, 2'b00, 19'h0};
		{b0, b1, b2, b3, n_mismatch, n_tests} = '0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		#1 `CHK(reg_pc, 16'h0000)
		for (int i = 0; i < 12; i++) begin
			for (int p = 0; p < 4; p++) ld(3'(p), 16'($random(seed)));
			r = 3'($random(seed));
			r = (r == 3'h6) ? 3'h7 : r;
			b = 3'($random(seed));
			v = get_r(r);
			f = reg_af[7:0];
			run({8'hCB, 2'(i % 3 + 1), b, r, 16'h0}, 8);
			case (i % 3)
			0: `CHK(reg_af[7:0] & 8'h53, (f & 8'h01) | 8'h10 | (v[b] ? 8'h00 : 8'h40))
			1: `CHK(get_r(r), v & ~(8'h01 << b))
			default: `CHK(get_r(r), v | (8'h01 << b))
			endcase
			if (i % 3 != 0) `CHK(reg_af[7:0], f)
		end
		$display("test register bits done");
		for (int i = 0; i < 4; i++) begin
			ld(3, 16'($random(seed)));
			ld(4, 16'($random(seed)));
			ld(0, 16'($random(seed)));
			{b, d, m} = 19'($random(seed));
			ea = (i == 1) ? reg_ix[7:0] + d : reg_hl[7:0];
			u_mem.mem[ea] = m;
			f = reg_af[7:0];
			case (i)
			0: run({8'hCB, 2'b11, b, 3'h6, 16'h0}, 15);
			1: run({8'hDD, 8'hCB, d, 2'b10, b, 3'h6}, 23);
			2: run({8'hCB, 2'b01, b, 3'h6, 16'h0}, 15);
			default: run({8'hCB, 8'h26, 16'h0}, 15);
			endcase
			case (i)
			0: `CHK(u_mem.mem[ea], m | (8'h01 << b))
			1: `CHK(u_mem.mem[ea], m & ~(8'h01 << b))
			2: `CHK(reg_af[7:0] & 8'h53, (f & 8'h01) | 8'h10 | (m[b] ? 8'h00 : 8'h40))
			default: `CHK(reg_af[7:0] & 8'hD7, szp({m[6:0], 1'b0}) | {7'h0, m[7]})
			endcase
			if (i < 2) `CHK(reg_af[7:0], f)
		end
		$display("test memory bits done");
		for (int p = 1; p < 4; p++) ld(3'(p), 16'($random(seed)));
		{bc0, de0, hl0, f} = {reg_bc, reg_de, reg_hl, reg_af[7:0]};
		run({8'hD9, 24'h0}, 4);
		`CHK({reg_bc, reg_de, reg_hl}, 48'h0)
		run({8'hD9, 24'h0}, 4);
		`CHK({reg_bc, reg_de, reg_hl, reg_af[7:0]}, {bc0, de0, hl0, f})
		ld(6, 16'h0040);
		{m, v} = 16'($random(seed));
		{u_mem.mem[8'h41], u_mem.mem[8'h40]} = {v, m};
		run({8'hE3, 24'h0}, 19);
		`CHK(reg_hl, {v, m})
		`CHK({u_mem.mem[8'h41], u_mem.mem[8'h40]}, hl0)
		run({8'hDD, 8'hE3, 16'h0}, 23);
		`CHK(reg_ix, hl0)
		$display("test exchanges done");
		for (int i = 0; i < 8; i++) begin
			ld(0, 16'($random(seed)));
			ld(1, i[2] ? 16'h0002 : 16'h0001);
			ld(2, 16'h0080);
			ld(3, 16'h0010);
			{a, f} = reg_af;
			m = i[2] ? a : 8'($random(seed));
			u_mem.mem[8'h10] = m;
			dir = i[0] ? 16'hFFFF : 16'h0001;
			pv = i[2] ? 8'h04 : 8'h00;
			run({8'hED, 4'hA, i[0], 2'b00, i[1], 16'h0}, 16);
			`CHK(reg_hl, 16'h0010 + dir)
			`CHK(reg_bc, i[2] ? 16'h0001 : 16'h0000)
			if (i[1]) `CHK(reg_af[7:0] & 8'hD7, cmpf(a, m) | pv | (f & 8'h01))
			else `CHK({u_mem.mem[8'h80], reg_de}, {m, 16'h0080 + dir})
			if (!i[1]) `CHK(reg_af[7:0] & 8'hD7, (f & 8'hC1) | pv)
		end
		$display("test single block done");
		for (int k = 0; k < 4; k++) begin
			ld(0, 16'($random(seed)));
			ld(1, 16'h0003);
			ld(2, 16'h0090);
			ld(3, 16'h0020);
			a = reg_af[15:8];
			dir = k[0] ? 16'hFFFF : 16'h0001;
			u_mem.mem[8'h20] = ~a;
			u_mem.mem[8'h20 + dir[7:0]] = a;
			j = 0;
			do begin
				m = u_mem.mem[reg_hl[7:0]];
				pc0 = reg_pc;
				last = (reg_bc == 16'h0001) || (k[1] && m == a);
				run({8'hED, 4'hB, k[0], 2'b00, k[1], 16'h0}, last ? 16 : 21);
				`CHK(reg_pc, last ? pc0 + 16'h0002 : pc0)
				j++;
			end while (!last && j < 4);
			`CHK(j, k[1] ? 2 : 3)
			`CHK(reg_hl, 16'(16'h0020 + dir * j))
			if (k[1]) `CHK(reg_af[7:0] & 8'h46, 8'h46)
			else `CHK(reg_af[7:0] & 8'h16, 8'h00)
		end
		$display("test repeat block done");
		ld(0, {8'h5A, 8'($random(seed))});
		f = reg_af[7:0];
		v = 8'($random(seed));
		u_mem.io[8'h33] = v;
		run({8'hDB, 8'h33, 16'h0}, 11);
		`CHK({reg_af, u_mem.io_addr}, {v, f, 16'h5A33})
		ld(1, 16'h0733);
		run({8'hED, 8'h50, 16'h0}, 12);
		`CHK({reg_de[15:8], u_mem.io_addr}, {v, 16'h0733})
		`CHK(reg_af[7:0] & 8'hD7, szp(v) | (f & 8'h01))
		ld(2, 16'($random(seed)));
		f = reg_af[7:0];
		run({8'hED, 8'h59, 16'h0}, 12);
		`CHK({u_mem.io[8'h33], reg_af[7:0]}, {reg_de[7:0], f})
		ld(1, 16'h0133);
		ld(3, 16'h0050);
		u_mem.io[8'h33] = v;
		run({8'hED, 8'hA2, 16'h0}, 16);
		`CHK({u_mem.mem[8'h50], reg_hl, reg_bc}, {v, 16'h0051, 16'h0033})
		`CHK(reg_af[7:0] & 8'h42, 8'h42)
		$display("test port transfers done");
		summarize();
	end
endmodule // tb_bit_block_io_instr_exec
`default_nettype wire
